/* File: pkg/fto_cfg.svh */
`ifndef FTO_CFG_SVH
`define FTO_CFG_SVH
// Register indices, byte address is index times four
`define FTO_IDX_ACOUS   8'h62
`define FTO_IDX_LIM_R1  8'h6A
`define FTO_IDX_LIM_LOC 8'h6B
`define FTO_IDX_LIM_R2  8'h6C
`define FTO_IDX_HYST_A  8'h6D
`define FTO_IDX_HYST_B  8'h6E
`define FTO_IDX_STATUS  8'h70
// Reset values
`define FTO_RST_LIMIT   8'hA4
`define FTO_RST_HYST_A  8'h44
`define FTO_RST_HYST_B  8'h40
`define FTO_RST_ACOUS   8'h00
// Field positions
`define FTO_KEEP_LSB    5
`define FTO_HYST_HI     7
`define FTO_HYST_LO     4
`define FTO_STAT_FAN    4
// Duty codes
`define FTO_DUTY_FULL   8'hFF
`define FTO_DUTY_OFF    8'h00
// Bus answers
`define FTO_RESP_OKAY   2'h0
`define FTO_RESP_SLVERR 2'h2
`endif

/* File: pkg/fto_pkg.sv */
package fto_pkg;
    // Temperature source of a fan
    typedef enum logic [1:0] {
        FTO_CH_REMOTE1,
        FTO_CH_LOCAL,
        FTO_CH_REMOTE2
    } fto_chan_t;

    // Per-fan inputs from the automatic loop
    typedef struct packed {
        logic [7:0] auto_duty;
        logic [7:0] fan_turn_on_temp;
        logic [7:0] minimum_duty;
        fto_chan_t  src;
    } fto_fan_t;
endpackage

/* File: core/fto_override.sv */
// The AXI4-Lite register port was chosen for this implementation.
`include "fto_cfg.svh"
// Summary of operation
// - Any channel above its critical limit drives every fan at full duty.
// - One channel violating its limit alone suffices for the override.
// - Override holds until temperature drops below limit minus hysteresis.
// - Override cannot be masked; it beats all automatic settings.
// - Three 8-bit critical limits at consecutive offsets, reset 0xA4.
// - Each hysteresis field resets to 4 degrees.
// - Hysteresis fields are 4 bits in 1 degree steps.
// - Zero hysteresis removes hysteresis; software should avoid it.
// - First hysteresis register: remote 1 upper nibble, local lower.
// - Second hysteresis register: remote 2 in upper nibble.
// - One hysteresis per channel serves override release and fan off.
// - A running fan stays on until below turn-on minus hysteresis.
// - Bits 7:5 pick fans 3:1; zero means off below turn-on minus hyst.
// - A set bit drives that fan's minimum duty instead of off.
// - A keep-spinning fan ignores hysteresis below turn-on temperature.
// - Full duty is code 255 on each fan drive.
module fto_override (
    // Clock and reset
    input  wire logic                      mclk,
    input  wire logic                      rst_b,
    // AXI4-Lite slave
    input  wire logic [11:0]               s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [11:0]               s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    // Measured temperatures: remote 1, local, remote 2
    input  wire logic [2:0][7:0]           chan_temp,
    // Automatic loop values per fan
    input  wire fto_pkg::fto_fan_t [2:0]   fan_cfg,
    // Fan drives and status
    output logic [7:0]                     fan_drive_1,
    output logic [7:0]                     fan_drive_2,
    output logic [7:0]                     fan_drive_3,
    output logic                           override_active
);

    ////////////////////////////////////////////////////////////////////
    // Register storage
    logic [2:0][7:0] limit_reg;
    logic [7:0]      acous_reg;
    logic [7:0]      hyst_a_reg;
    logic [3:0]      hyst_b_reg;
    logic [2:0]      ovr_reg;
    logic [2:0]      fan_on_reg;
    logic [2:0][7:0] drive_reg;
    logic [2:0][3:0] hyst;

    // Nibble mapping of the hysteresis fields
    assign hyst[0] = hyst_a_reg[`FTO_HYST_HI:`FTO_HYST_LO];
    assign hyst[1] = hyst_a_reg[3:0];
    assign hyst[2] = hyst_b_reg;

    ////////////////////////////////////////////////////////////////////
    // AXI write path: address and data caught independently
    logic        aw_full_reg;
    logic        w_full_reg;
    logic [11:0] aw_addr_reg;
    logic [7:0]  w_data_reg;
    logic        w_strb_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        do_wr;
    logic        wr_hit;
    logic [7:0]  wr_idx;

    assign s_axi_awready = !aw_full_reg;
    assign s_axi_wready  = !w_full_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign do_wr  = aw_full_reg && w_full_reg && !bvalid_reg;
    assign wr_idx = aw_addr_reg[9:2];

    // Decode of a mapped index; upper address bits must be zero
    function automatic logic mapped(input logic [11:0] a);
        logic [7:0] i;
        i = a[9:2];
        mapped = (a[11:10] == 2'h0) &&
                 (i == `FTO_IDX_ACOUS || i == `FTO_IDX_LIM_R1 ||
                  i == `FTO_IDX_LIM_LOC || i == `FTO_IDX_LIM_R2 ||
                  i == `FTO_IDX_HYST_A || i == `FTO_IDX_HYST_B ||
                  i == `FTO_IDX_STATUS);
    endfunction

    assign wr_hit = mapped(aw_addr_reg) && (wr_idx != `FTO_IDX_STATUS);

    // Capture of address beat
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= 12'h000;
        end else if (do_wr) begin
            aw_full_reg <= 1'b0;
        end else if (s_axi_awvalid && !aw_full_reg) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end
    end

    // Capture of data beat, only the low lane is kept
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            w_full_reg <= 1'b0;
            w_data_reg <= 8'h00;
            w_strb_reg <= 1'b0;
        end else if (do_wr) begin
            w_full_reg <= 1'b0;
        end else if (s_axi_wvalid && !w_full_reg) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata[7:0];
            w_strb_reg <= s_axi_wstrb[0];
        end
    end

    // Write response
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= `FTO_RESP_OKAY;
        end else if (do_wr) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_hit ? `FTO_RESP_OKAY : `FTO_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Configuration registers
    logic wr_en;
    assign wr_en = do_wr && wr_hit && w_strb_reg;

    // Critical limits, consecutive indices
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            limit_reg <= {3{`FTO_RST_LIMIT}};
        end else if (wr_en && wr_idx == `FTO_IDX_LIM_R1) begin
            limit_reg[0] <= w_data_reg;
        end else if (wr_en && wr_idx == `FTO_IDX_LIM_LOC) begin
            limit_reg[1] <= w_data_reg;
        end else if (wr_en && wr_idx == `FTO_IDX_LIM_R2) begin
            limit_reg[2] <= w_data_reg;
        end
    end

    // Hysteresis fields; zero is accepted as written
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            hyst_a_reg <= `FTO_RST_HYST_A;
            hyst_b_reg <= 4'(`FTO_RST_HYST_B >> `FTO_HYST_LO);
        end else if (wr_en && wr_idx == `FTO_IDX_HYST_A) begin
            hyst_a_reg <= w_data_reg;
        end else if (wr_en && wr_idx == `FTO_IDX_HYST_B) begin
            hyst_b_reg <= w_data_reg[`FTO_HYST_HI:`FTO_HYST_LO];
        end
    end

    // Acoustics register, all bits stored
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            acous_reg <= `FTO_RST_ACOUS;
        end else if (wr_en && wr_idx == `FTO_IDX_ACOUS) begin
            acous_reg <= w_data_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // AXI read path
    logic        rvalid_reg;
    logic [7:0]  rdata_reg;
    logic [1:0]  rresp_reg;
    logic [7:0]  rd_mux;
    logic [7:0]  rd_idx;

    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = {24'h000000, rdata_reg};
    assign s_axi_rresp   = rresp_reg;
    assign rd_idx        = s_axi_araddr[9:2];

    // Read mux; reserved nibble of second hysteresis reads zero
    always_comb begin
        rd_mux = 8'h00;
        case (rd_idx)
            `FTO_IDX_ACOUS:   rd_mux = acous_reg;
            `FTO_IDX_LIM_R1:  rd_mux = limit_reg[0];
            `FTO_IDX_LIM_LOC: rd_mux = limit_reg[1];
            `FTO_IDX_LIM_R2:  rd_mux = limit_reg[2];
            `FTO_IDX_HYST_A:  rd_mux = hyst_a_reg;
            `FTO_IDX_HYST_B:  rd_mux = {hyst_b_reg, 4'h0};
            `FTO_IDX_STATUS:  rd_mux = {1'b0, fan_on_reg, 1'b0, ovr_reg};
            default:          rd_mux = 8'h00;
        endcase
    end

    // Read answer held until rready
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 8'h00;
            rresp_reg  <= `FTO_RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= mapped(s_axi_araddr) ? rd_mux : 8'h00;
            rresp_reg  <= mapped(s_axi_araddr) ? `FTO_RESP_OKAY
                                               : `FTO_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Per-channel override flags
    logic [2:0] ovr_set;
    logic [2:0] ovr_clr;

    genvar c;
    generate
        for (c = 0; c < 3; c++) begin : g_chan
            // Adding hyst to temp avoids an underflowing limit - hyst
            assign ovr_set[c] = chan_temp[c] > limit_reg[c];
            assign ovr_clr[c] = ({1'b0, chan_temp[c]} + {5'h00, hyst[c]})
                                < {1'b0, limit_reg[c]};

            // Set beats clear so no over-limit sample is lost
            always_ff @(posedge mclk or negedge rst_b) begin
                if (!rst_b) begin
                    ovr_reg[c] <= 1'b0;
                end else if (ovr_set[c]) begin
                    ovr_reg[c] <= 1'b1;
                end else if (ovr_clr[c]) begin
                    ovr_reg[c] <= 1'b0;
                end
            end

            AST_OVR_SET: assert property (@(posedge mclk) disable iff (!rst_b)
                ovr_set[c] |=> ovr_reg[c])
                else $error("channel over limit did not enter override");
            AST_OVR_HOLD: assert property (@(posedge mclk) disable iff (!rst_b)
                ovr_reg[c] && !ovr_clr[c] |=> ovr_reg[c])
                else $error("override released above limit minus hyst");
            AST_OVR_REL: assert property (@(posedge mclk) disable iff (!rst_b)
                ovr_reg[c] && ovr_clr[c] && !ovr_set[c] |=> !ovr_reg[c])
                else $error("override not released below threshold");
        end
    endgenerate

    assign override_active = |ovr_reg;

    ////////////////////////////////////////////////////////////////////
    // Per-fan on/off state and drive selection
    genvar f;
    generate
        for (f = 0; f < 3; f++) begin : g_fan
            logic [7:0] t;
            logic [3:0] h;
            logic       keep;
            logic       on_set;
            logic       on_clr;
            logic [7:0] drv_next;

            assign t = chan_temp[fan_cfg[f].src == fto_pkg::FTO_CH_REMOTE2 ? 2 :
                                 fan_cfg[f].src == fto_pkg::FTO_CH_LOCAL ? 1 : 0];
            assign h = hyst[fan_cfg[f].src == fto_pkg::FTO_CH_REMOTE2 ? 2 :
                            fan_cfg[f].src == fto_pkg::FTO_CH_LOCAL ? 1 : 0];
            assign keep   = acous_reg[`FTO_KEEP_LSB + f];
            assign on_set = t > fan_cfg[f].fan_turn_on_temp;
            assign on_clr = ({1'b0, t} + {5'h00, h})
                            < {1'b0, fan_cfg[f].fan_turn_on_temp};

            // Running state, set wins
            always_ff @(posedge mclk or negedge rst_b) begin
                if (!rst_b) begin
                    fan_on_reg[f] <= 1'b0;
                end else if (on_set) begin
                    fan_on_reg[f] <= 1'b1;
                end else if (on_clr) begin
                    fan_on_reg[f] <= 1'b0;
                end
            end

            // Override first, unconditionally, then keep or off
            always_comb begin
                drv_next = fan_cfg[f].auto_duty;
                if (|ovr_reg) begin
                    drv_next = `FTO_DUTY_FULL;
                end else if (keep) begin
                    // Hysteresis ignored: below turn-on use minimum
                    if (t < fan_cfg[f].fan_turn_on_temp) begin
                        drv_next = fan_cfg[f].minimum_duty;
                    end
                end else if (!fan_on_reg[f]) begin
                    drv_next = `FTO_DUTY_OFF;
                end
            end

            always_ff @(posedge mclk or negedge rst_b) begin
                if (!rst_b) begin
                    drive_reg[f] <= `FTO_DUTY_OFF;
                end else begin
                    drive_reg[f] <= drv_next;
                end
            end

            AST_FULL: assert property (@(posedge mclk) disable iff (!rst_b)
                |ovr_reg |=> drive_reg[f] == 8'hFF)
                else $error("override did not force full duty");
            AST_ANYCH: assert property (@(posedge mclk) disable iff (!rst_b)
                |ovr_set |-> ##2 drive_reg[f] == 8'hFF)
                else $error("single channel violation missed");
            AST_OFF: assert property (@(posedge mclk) disable iff (!rst_b)
                !(|ovr_reg) && !keep && !fan_on_reg[f] |=> drive_reg[f] == 8'h00)
                else $error("fan not off below turn-on minus hyst");
            AST_KEEP: assert property (@(posedge mclk) disable iff (!rst_b)
                !(|ovr_reg) && keep && t < fan_cfg[f].fan_turn_on_temp
                |=> drive_reg[f] == $past(fan_cfg[f].minimum_duty))
                else $error("keep-spinning fan not at minimum duty");
            AST_ON_HOLD: assert property (@(posedge mclk) disable iff (!rst_b)
                fan_on_reg[f] && !on_clr |=> fan_on_reg[f])
                else $error("fan turned off above turn-on minus hyst");
        end
    endgenerate

    assign fan_drive_1 = drive_reg[0];
    assign fan_drive_2 = drive_reg[1];
    assign fan_drive_3 = drive_reg[2];

    ////////////////////////////////////////////////////////////////////
    // Bus answer stability
    AST_BSTABLE: assert property (@(posedge mclk) disable iff (!rst_b)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before bready");
    AST_RSTABLE: assert property (@(posedge mclk) disable iff (!rst_b)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before rready");

endmodule // fto_override

/* File: dv/fto_override_tb.sv */
module fto_override_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // Clock, reset, bus
    logic                       mclk;
    logic                       rst_b;
    logic [11:0]                s_axi_awaddr, s_axi_araddr;
    logic                       s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0]                s_axi_wdata, s_axi_rdata;
    logic [3:0]                 s_axi_wstrb;
    logic [1:0]                 s_axi_bresp, s_axi_rresp;
    logic                       s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic                       s_axi_rvalid, s_axi_rready;
    // Thermal side
    logic [2:0][7:0]            chan_temp;
    fto_pkg::fto_fan_t [2:0]    fan_cfg;
    logic [7:0]                 fan_drive_1, fan_drive_2, fan_drive_3;
    logic                       override_active;
    int                         fail_count = 0;
    int                         n_compared = 0;
    // Hysteresis per channel as programmed below: R1, local, R2
    logic [7:0]                 hyst_c [3] = '{8'h03, 8'h05, 8'h07};

    fto_override DUT (.mclk(mclk), .rst_b(rst_b),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .chan_temp(chan_temp),
        .fan_cfg(fan_cfg), .fan_drive_1(fan_drive_1), .fan_drive_2(fan_drive_2),
        .fan_drive_3(fan_drive_3), .override_active(override_active));

    // 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict, comparison, bus tasks
    task automatic report_and_stop;
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // A missing answer ends the run at once
    task automatic hang(input string what);
        fail_count++;
        $display("wrong value %s expected answer seen none", what);
        report_and_stop();
    endtask

    // Ready lines stay high, so each channel drops once taken
    task automatic axi_write(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
        bit got;
        got = 1'b0;
        s_axi_awaddr  <= {2'h0, idx, 2'h0};
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= {24'h0, d};
        s_axi_wvalid  <= 1'b1;
        for (int n = 0; n < 40 && !got; n++) begin
            @(posedge mclk);
            if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                got = 1'b1;
                check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
            end
        end
        if (!got) hang("bvalid");
    endtask

    task automatic axi_read(input logic [7:0] idx, input logic [7:0] ed, input logic [1:0] er);
        bit got;
        got = 1'b0;
        s_axi_araddr  <= {2'h0, idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        for (int n = 0; n < 40 && !got; n++) begin
            @(posedge mclk);
            if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                got = 1'b1;
                check("rdata", s_axi_rdata, {24'h0, ed});
                check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
            end
        end
        if (!got) hang("rvalid");
    endtask

    // Lets the two-edge drive path settle before looking
    task automatic check_fans(input logic [7:0] e0, e1, e2, input logic ov);
        repeat (4) @(posedge mclk);
        check("fan_drive_1", {24'h0, fan_drive_1}, {24'h0, e0});
        check("fan_drive_2", {24'h0, fan_drive_2}, {24'h0, e1});
        check("fan_drive_3", {24'h0, fan_drive_3}, {24'h0, e2});
        check("override_active", {31'h0, override_active}, {31'h0, ov});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic test_reset_values;
        for (int c = 0; c < 3; c++) begin
            axi_read(8'h6A + 8'(c), 8'hA4, 2'h0);
        end
        axi_read(8'h6D, 8'h44, 2'h0);
        axi_read(8'h6E, 8'h40, 2'h0);
        axi_read(8'h62, 8'h00, 2'h0);
        axi_read(8'h69, 8'h00, 2'h2);
        axi_read(8'h70, 8'h00, 2'h0);
        check_fans(8'h00, 8'h00, 8'h00, 1'b0);
    endtask

    task automatic test_registers;
        axi_write(8'h6D, 8'h35, 2'h0);
        axi_write(8'h6E, 8'h7F, 2'h0);
        axi_read(8'h6D, 8'h35, 2'h0);
        axi_read(8'h6E, 8'h70, 2'h0);
        for (int c = 0; c < 3; c++) begin
            axi_write(8'h6A + 8'(c), 8'h90 + 8'(c), 2'h0);
            axi_read(8'h6A + 8'(c), 8'h90 + 8'(c), 2'h0);
        end
        // Low strobe clear: answered OKAY, nothing stored
        s_axi_wstrb <= 4'hE;
        axi_write(8'h6A, 8'h55, 2'h0);
        s_axi_wstrb <= 4'hF;
        axi_read(8'h6A, 8'h90, 2'h0);
        axi_write(8'h70, 8'hFF, 2'h2);
        axi_write(8'h69, 8'h12, 2'h2);
    endtask

    // Each channel alone forces override; release uses its own hysteresis
    task automatic test_override;
        logic [7:0]      lim;
        logic [2:0][7:0] exp;
        for (int c = 0; c < 3; c++) begin
            lim = 8'h90 + 8'(c);
            exp = '0;
            exp[c] = 8'h40 + 8'(c);
            chan_temp[c] <= lim + 8'h01;
            check_fans(8'hFF, 8'hFF, 8'hFF, 1'b1);
            chan_temp[c] <= lim - hyst_c[c];
            check_fans(8'hFF, 8'hFF, 8'hFF, 1'b1);
            chan_temp[c] <= lim - hyst_c[c] - 8'h01;
            check_fans(exp[0], exp[1], exp[2], 1'b0);
            chan_temp[c] <= 8'h30;
            check_fans(8'h00, 8'h00, 8'h00, 1'b0);
        end
    endtask

    task automatic test_two_channels;
        chan_temp[0] <= 8'h91;
        chan_temp[2] <= 8'h93;
        check_fans(8'hFF, 8'hFF, 8'hFF, 1'b1);
        // Status: override flags R1 and R2, fans 1 and 3 running
        axi_read(8'h70, 8'h55, 2'h0);
        chan_temp[0] <= 8'h30;
        check_fans(8'hFF, 8'hFF, 8'hFF, 1'b1);
        axi_read(8'h70, 8'h44, 2'h0);
        chan_temp[2] <= 8'h30;
        check_fans(8'h00, 8'h00, 8'h00, 1'b0);
    endtask

    // Local channel, hysteresis 5, turn-on 0x50
    task automatic test_fan_hyst;
        chan_temp[1] <= 8'h51;
        check_fans(8'h00, 8'h41, 8'h00, 1'b0);
        chan_temp[1] <= 8'h4B;
        check_fans(8'h00, 8'h41, 8'h00, 1'b0);
        chan_temp[1] <= 8'h4A;
        check_fans(8'h00, 8'h00, 8'h00, 1'b0);
    endtask

    task automatic test_keep_spinning;
        logic [2:0][7:0] exp;
        for (int j = 0; j < 3; j++) begin
            exp = '0;
            exp[j] = 8'h20 + 8'(j);
            axi_write(8'h62, 8'(8'h20 << j), 2'h0);
            check_fans(exp[0], exp[1], exp[2], 1'b0);
        end
        axi_write(8'h62, 8'hE0, 2'h0);
        chan_temp[1] <= 8'h51;
        check_fans(8'h20, 8'h41, 8'h22, 1'b0);
        chan_temp[1] <= 8'h4F;
        check_fans(8'h20, 8'h21, 8'h22, 1'b0);
        chan_temp[0] <= 8'h91;
        check_fans(8'hFF, 8'hFF, 8'hFF, 1'b1);
        chan_temp[0] <= 8'h30;
        chan_temp[1] <= 8'h30;
        check_fans(8'h20, 8'h21, 8'h22, 1'b0);
        axi_write(8'h62, 8'h00, 2'h0);
    endtask

    // Zero hysteresis: release as soon as the limit is no longer reached
    task automatic test_zero_hyst;
        axi_write(8'h6E, 8'h00, 2'h0);
        chan_temp[2] <= 8'h93;
        check_fans(8'hFF, 8'hFF, 8'hFF, 1'b1);
        chan_temp[2] <= 8'h92;
        check_fans(8'hFF, 8'hFF, 8'hFF, 1'b1);
        chan_temp[2] <= 8'h91;
        check_fans(8'h00, 8'h00, 8'h42, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst_b = 1'b0;
        s_axi_awaddr = 12'h000;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b1;
        s_axi_araddr = 12'h000;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b1;
        chan_temp = {3{8'h30}};
        for (int j = 0; j < 3; j++) begin
            fan_cfg[j] = '{auto_duty: 8'h40 + 8'(j), fan_turn_on_temp: 8'h50,
                           minimum_duty: 8'h20 + 8'(j), src: fto_pkg::fto_chan_t'(j)};
        end
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        test_reset_values();
        test_registers();
        test_override();
        test_two_channels();
        test_fan_hyst();
        test_keep_spinning();
        test_zero_hyst();
        report_and_stop();
    end
endmodule // fto_override_tb
